// ==== hdl/bus_edge_pkg.sv ====
package bus_edge_pkg;
  localparam int unsigned LANE_W        = 8;
  localparam int unsigned UPPER_LANES   = 2;
  localparam int unsigned IRQ_COUNT     = 8;
  localparam int unsigned DMA_CH        = 2;
  localparam int unsigned BURST_BEATS   = 4;
  localparam int unsigned BEAT_CNT_W    = 3;
  // hung-bus watchdog, in bus clocks (25 MHz)
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned HANG_US       = 10;
  localparam int unsigned HANG_CYCLES   = HANG_US * CLK_MHZ;
  localparam int unsigned HANG_CNT_W    = 9;

  typedef enum logic [1:0] {
    XFER_SINGLE,
    XFER_BURST,
    XFER_DMA_SPLIT
  } xfer_kind_t;
endpackage

// ==== hdl/parity_lane_if.sv ====
`timescale 1ns/1ps
interface parity_lane_if;
  logic [7:0] data;
  logic       parity;
  logic       ok;
  modport gen (input data, output parity, output ok);
  modport use_side (output data, input parity, input ok);
endinterface

// ==== hdl/odd_parity_lane.sv ====
`timescale 1ns/1ps
module odd_parity_lane (
  parity_lane_if.gen lane,
  input  wire logic  rx_parity
);
  // odd parity: data plus parity hold an odd count of ones
  assign lane.parity = ~^lane.data;
  assign lane.ok     = ^{lane.data, rx_parity};
endmodule

// ==== hdl/bus_edge.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - driver of lanes 48..55 gives odd parity over lane and its parity
// - driver of lanes 56..63 gives odd parity over lane and its parity
// - internal dma asserts its acknowledge output per request channel
// - eight external interrupt request inputs reach the interrupt logic
// - single transfer: one transfer_ack, which also ends it
// - burst: four beat_valid beats, transfer_ack on the last ends the burst
// - transfer_error_ack flags bus error; internal masters watch it
// - bus monitor drives transfer_error_ack on a hung transfer
// - external non-maskable input raises internal non-maskable request
// - nmi output held while non-maskable interrupt awaits host service
// - general interrupt output while any unmasked interrupt pends
// - beat_valid on every beat, transfer_ack only on terminating beat
// - transfer_ack always comes with beat_valid in the same beat
// - two 64-bit words to 32-bit port: three beat_valid, then both
module bus_edge
  import bus_edge_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic [15:0]            data_hi_in,
  input  wire logic                   data_hi_drive,
  input  wire logic [15:0]            data_hi_out_src,
  output logic [15:0]                 data_hi_out,
  output logic                        data_hi_oe,
  input  wire logic                   parity_lane_six_in,
  input  wire logic                   parity_lane_seven_in,
  output logic                        parity_lane_six_out,
  output logic                        parity_lane_six_oe,
  output logic                        parity_lane_seven_out,
  output logic                        parity_lane_seven_oe,
  output logic [1:0]                  parity_err,
  input  wire logic                   xfer_start,
  input  wire bus_edge_pkg::xfer_kind_t xfer_kind,
  input  wire logic                   beat_ready,
  input  wire logic                   dma_xfer,
  input  wire logic                   dma_ch_sel,
  output logic                        dma_ack_ch3,
  output logic                        dma_ack_ch4,
  output logic                        transfer_ack_out,
  output logic                        transfer_ack_oe,
  output logic                        beat_valid_out,
  output logic                        beat_valid_oe,
  input  wire logic                   transfer_ack_in,
  input  wire logic                   beat_valid_in,
  input  wire logic                   transfer_error_ack_in,
  output logic                        transfer_error_ack_out,
  output logic                        transfer_error_ack_oe,
  output logic                        master_abort,
  output logic                        xfer_busy,
  input  wire logic [7:0]             ext_irq_line,
  input  wire logic [7:0]             irq_mask,
  input  wire logic [7:0]             irq_clear,
  input  wire logic                   nmi_in,
  input  wire logic                   nmi_serviced,
  output logic [7:0]                  irq_pending,
  output logic                        core_nmi_req,
  output logic                        nmi_out,
  output logic                        int_out
);
  typedef enum logic [1:0] {IDLE, BEATS, HUNG} state_t;

  state_t                  state_q, state_d, state_n;
  logic                    busy_q;
  logic [BEAT_CNT_W-1:0]   beats_left_q, beats_left_d;
  logic [HANG_CNT_W-1:0]   wait_q;
  logic                    drive_q;
  logic [15:0]             data_q;
  logic [1:0]              par_q;
  logic [1:0]              perr_q;
  logic                    ta_q, dv_q, tea_q, abort_q;
  logic                    dma_ack_ch3_q, dma_ack_ch4_q, is_dma_q;
  logic                    dma_sel_q;
  logic [7:0]              irq_pend_q;
  logic                    nmi_pend_q, nmi_prev_q, core_nmi_q;
  logic                    nmi_out_q, int_out_q;

  parity_lane_if lane6 ();
  parity_lane_if lane7 ();

  assign lane6.data = drive_q ? data_q[7:0]  : data_hi_in[7:0];
  assign lane7.data = drive_q ? data_q[15:8] : data_hi_in[15:8];

  odd_parity_lane u_lane6 (.lane(lane6), .rx_parity(parity_lane_six_in));
  odd_parity_lane u_lane7 (.lane(lane7), .rx_parity(parity_lane_seven_in));

  // beat bookkeeping
  wire       beat_fire  = (state_q == BEATS) && beat_ready;
  wire       last_beat  = beat_fire && (beats_left_q == 3'h1);
  wire       err_seen   = transfer_error_ack_in && (state_q != IDLE);
  wire       hang_hit   = (state_q == BEATS) && !beat_ready &&
                          (wait_q == HANG_CNT_W'(HANG_CYCLES - 1));
  wire [2:0] init_beats = (xfer_kind == XFER_SINGLE) ? 3'h1 :
                          BEAT_CNT_W'(BURST_BEATS);
  wire       unmasked   = |(irq_pend_q & ~irq_mask);
  wire       nmi_rise   = nmi_in && !nmi_prev_q;
  wire       dma_beat   = beat_fire && !err_seen && is_dma_q;

  // a hang parks one cycle in HUNG before going idle
  assign state_n = hang_hit ? HUNG : state_d;

  always_comb begin
    state_d      = state_q;
    beats_left_d = beats_left_q;
    unique case (state_q)
      IDLE: begin
        if (xfer_start) begin
          state_d      = BEATS;
          beats_left_d = init_beats;
        end
      end
      BEATS: begin
        if (err_seen || hang_hit) begin
          state_d = IDLE;
        end else if (last_beat) begin
          state_d = IDLE;
        end else if (beat_fire) begin
          beats_left_d = beats_left_q - 3'h1;
        end
      end
      HUNG: state_d = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q      <= IDLE;
      busy_q       <= 1'b0;
      beats_left_q <= 3'h0;
      wait_q       <= '0;
      is_dma_q     <= 1'b0;
      dma_sel_q    <= 1'b0;
    end else begin
      state_q      <= state_n;
      busy_q       <= (state_n != IDLE);
      beats_left_q <= beats_left_d;
      wait_q       <= (beat_fire || state_q != BEATS) ? '0 : wait_q + 1'b1;
      if (xfer_start && state_q == IDLE) begin
        is_dma_q  <= dma_xfer;
        dma_sel_q <= dma_ch_sel;
      end
    end
  end

  // beat strobes: valid on each beat, ack only on the final one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dv_q    <= 1'b0;
      ta_q    <= 1'b0;
      tea_q   <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      dv_q    <= beat_fire && !err_seen;
      ta_q    <= last_beat && !err_seen;
      tea_q   <= hang_hit;
      abort_q <= err_seen || hang_hit;
    end
  end

  // dma acknowledges follow the owning channel's beats
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dma_ack_ch3_q <= 1'b0;
      dma_ack_ch4_q <= 1'b0;
    end else begin
      dma_ack_ch3_q <= dma_beat && !dma_sel_q;
      dma_ack_ch4_q <= dma_beat && dma_sel_q;
    end
  end

  // parity drive and check
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drive_q <= 1'b0;
      data_q  <= 16'h0000;
      par_q   <= 2'h0;
      perr_q  <= 2'h0;
    end else begin
      drive_q <= data_hi_drive;
      data_q  <= data_hi_out_src;
      par_q   <= {~^data_hi_out_src[15:8],
                  ~^data_hi_out_src[7:0]};
      perr_q  <= (!drive_q && beat_valid_in) ?
                 {~lane7.ok, ~lane6.ok} : 2'h0;
    end
  end

  // interrupt edge: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_pend_q <= 8'h00;
      nmi_pend_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      core_nmi_q <= 1'b0;
      nmi_out_q  <= 1'b0;
      int_out_q  <= 1'b0;
    end else begin
      irq_pend_q <= (irq_pend_q & ~irq_clear) | ext_irq_line;
      nmi_prev_q <= nmi_in;
      core_nmi_q <= nmi_rise;
      nmi_pend_q <= nmi_rise || (nmi_pend_q && !nmi_serviced);
      nmi_out_q  <= nmi_pend_q;
      int_out_q  <= unmasked;
    end
  end

  assign data_hi_out            = data_q;
  assign data_hi_oe             = drive_q;
  assign parity_lane_six_out    = par_q[0];
  assign parity_lane_six_oe     = drive_q;
  assign parity_lane_seven_out  = par_q[1];
  assign parity_lane_seven_oe   = drive_q;
  assign parity_err             = perr_q;
  assign dma_ack_ch3            = dma_ack_ch3_q;
  assign dma_ack_ch4            = dma_ack_ch4_q;
  assign transfer_ack_out       = ta_q;
  assign transfer_ack_oe        = dv_q;
  assign beat_valid_out         = dv_q;
  assign beat_valid_oe          = dv_q;
  assign transfer_error_ack_out = tea_q;
  assign transfer_error_ack_oe  = tea_q;
  assign master_abort           = abort_q;
  assign xfer_busy              = busy_q;
  assign irq_pending            = irq_pend_q;
  assign core_nmi_req           = core_nmi_q;
  assign nmi_out                = nmi_out_q;
  assign int_out                = int_out_q;
endmodule

// ==== tb/bus_edge_assertions.sv ====
`timescale 1ns/1ps
module bus_edge_assertions (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [15:0] data_hi_out,
  input wire logic        data_hi_oe,
  input wire logic        parity_lane_six_out,
  input wire logic        parity_lane_seven_out,
  input wire logic        xfer_busy,
  input wire logic        transfer_ack_out,
  input wire logic        beat_valid_out,
  input wire logic        dma_ack_ch3,
  input wire logic        transfer_error_ack_in,
  input wire logic        transfer_error_ack_out,
  input wire logic        master_abort,
  input wire logic        nmi_in,
  input wire logic        nmi_out,
  input wire logic        core_nmi_req,
  input wire logic [7:0]  irq_pending,
  input wire logic [7:0]  irq_mask,
  input wire logic        int_out
);
  wire unmasked_w = |(irq_pending & ~irq_mask);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  par_six_a: assert property (
    data_hi_oe |-> ^{data_hi_out[7:0], parity_lane_six_out})
    else $error("lane six parity even");
  par_seven_a: assert property (
    data_hi_oe |-> ^{data_hi_out[15:8], parity_lane_seven_out})
    else $error("lane seven parity even");
  ack_valid_a: assert property (transfer_ack_out |-> beat_valid_out)
    else $error("ack without beat valid");
  ack_end_a: assert property (transfer_ack_out |-> !xfer_busy)
    else $error("ack did not end transfer");
  dma_beat_a: assert property (dma_ack_ch3 |-> beat_valid_out)
    else $error("dma ack off beat");
  hang_abort_a: assert property (transfer_error_ack_out |-> master_abort)
    else $error("hang without abort");
  err_end_a: assert property (
    xfer_busy && transfer_error_ack_in |=> master_abort && !beat_valid_out)
    else $error("beat after error");
  nmi_req_a: assert property ($rose(nmi_in) |-> ##[1:2] core_nmi_req)
    else $error("no core nmi request");
  nmi_out_a: assert property ($rose(nmi_in) |-> ##2 nmi_out)
    else $error("nmi output late");
  int_out_a: assert property (
    1 |=> int_out == $past(unmasked_w))
    else $error("int output wrong");
  cover property (transfer_ack_out);
  cover property (transfer_error_ack_out);
  cover property (nmi_out && int_out);
endmodule
bind bus_edge bus_edge_assertions chk_u (.*);

// ==== tb/bus_far_agent.sv ====
`timescale 1ns/1ps
module bus_far_agent (
  input  wire logic       sys_clk,
  input  wire logic       xfer_busy,
  input  wire logic       stall,
  input  wire logic [1:0] bad_par,
  output logic            beat_ready = 1'b0,
  output logic            beat_valid_in = 1'b0,
  output logic [15:0]     data_hi_in = 16'h0000,
  output logic            parity_lane_six_in = 1'b1,
  output logic            parity_lane_seven_in = 1'b1
);
  logic [15:0] pat_q = 16'hA5C3;
  // data pattern moves every cycle so stale lanes never look valid
  always @(negedge sys_clk) begin
    pat_q <= {pat_q[14:0], pat_q[15] ^ pat_q[13]};
    beat_ready <= xfer_busy & ~stall;
    beat_valid_in <= xfer_busy & ~stall;
    data_hi_in <= pat_q;
    parity_lane_six_in <= ~^pat_q[7:0] ^ bad_par[0];
    parity_lane_seven_in <= ~^pat_q[15:8] ^ bad_par[1];
  end
endmodule

// ==== tb/system_bus_beat_parity_irq_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module system_bus_beat_parity_irq_tb_top;
  import bus_edge_pkg::*;
  logic sys_clk = 0, reset = 1, data_hi_drive = 0, xfer_start = 0;
  logic dma_xfer = 0, dma_ch_sel = 0, transfer_ack_in = 0, nmi_in = 0;
  logic transfer_error_ack_in = 0, nmi_serviced = 0, stall = 0;
  logic [1:0] bad_par = 0, seen_pe = 0, parity_err;
  logic [15:0] data_hi_out_src = 0, data_hi_in, data_hi_out;
  logic [7:0] ext_irq_line = 0, irq_mask = 0, irq_clear = 0, irq_pending;
  xfer_kind_t xfer_kind = XFER_SINGLE;
  logic data_hi_oe, parity_lane_six_in, parity_lane_seven_in, beat_ready;
  logic parity_lane_six_out, parity_lane_six_oe, parity_lane_seven_out;
  logic parity_lane_seven_oe, dma_ack_ch3, dma_ack_ch4, transfer_ack_out;
  logic transfer_ack_oe, beat_valid_out, beat_valid_oe, beat_valid_in;
  logic transfer_error_ack_out, transfer_error_ack_oe, master_abort;
  logic xfer_busy, core_nmi_req, nmi_out, int_out;
  logic [2:0] exp_q[$], e;
  logic [31:0] lfsr = 32'hE7101ADE;
  int num_errors = 0, total_checks = 0;
  wire [2:0] beat_tag = {transfer_ack_out, dma_ack_ch3, dma_ack_ch4};
  bus_edge dut_u (.*);
  bus_far_agent far_u (.*);
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic kick(input xfer_kind_t k, input logic dma, input logic ch);
    xfer_kind = k;
    dma_xfer = dma;
    dma_ch_sel = ch;
    xfer_start = 1;
    @(negedge sys_clk);
    xfer_start = 0;
    @(negedge sys_clk);
  endtask
  task automatic xfer(input xfer_kind_t k, input logic dma, input logic ch);
    int n;
    n = (k == XFER_SINGLE) ? 1 : BURST_BEATS;
    for (int i = 1; i <= n; i++)
      exp_q.push_back({i == n, dma & ~ch, dma & ch});
    kick(k, dma, ch);
    for (int j = 0; j < 300 && xfer_busy; j++)
      @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) if (!reset) begin
    seen_pe |= parity_err;
    if (beat_valid_out) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h7;
      `CHK("beat ack dma", e, beat_tag)
      `CHK("beat oe", 2'b11, {beat_valid_oe, transfer_ack_oe})
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 0;
    @(negedge sys_clk);
    for (int k = 0; k < 5; k++)
      xfer(xfer_kind_t'(k % 3), k > 1, k == 4);
    repeat (3) @(negedge sys_clk);
    `CHK("parity flags", 2'b00, seen_pe)
    for (int b = 1; b < 3; b++) begin
      seen_pe = 0;
      bad_par = b[1:0];
      xfer(XFER_SINGLE, 0, 0);
      repeat (3) @(negedge sys_clk);
      bad_par = 0;
      `CHK("bad parity flag", b[1:0], seen_pe)
    end
    // two beats move before the error cuts the burst
    exp_q.push_back(3'b000);
    exp_q.push_back(3'b000);
    kick(XFER_BURST, 0, 0);
    @(negedge sys_clk);
    transfer_error_ack_in = 1;
    @(negedge sys_clk);
    transfer_error_ack_in = 0;
    `CHK("error abort", 1'b1, master_abort)
    repeat (6) @(negedge sys_clk);
    stall = 1;
    kick(XFER_BURST, 0, 0);
    for (int j = 0; j < 300 && !transfer_error_ack_out; j++)
      @(negedge sys_clk);
    `CHK("hang error", 1'b1, transfer_error_ack_out)
    `CHK("hang error oe", 1'b1, transfer_error_ack_oe)
    `CHK("hang abort", 1'b1, master_abort)
    stall = 0;
    data_hi_drive = 1;
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      data_hi_out_src = lfsr[15:0];
      @(negedge sys_clk);
      `CHK("lane six par", ~^lfsr[7:0], parity_lane_six_out)
      `CHK("lane seven par", ~^lfsr[15:8], parity_lane_seven_out)
      `CHK("data out", lfsr[15:0], data_hi_out)
      `CHK("lane oe", 1'b1, data_hi_oe & parity_lane_six_oe)
      `CHK("seven oe", 1'b1, parity_lane_seven_oe)
    end
    data_hi_drive = 0;
    for (int i = 0; i < 8; i++) begin
      ext_irq_line = 8'h01 << i;
      repeat (3) @(negedge sys_clk);
      `CHK("irq pending", 8'h01 << i, irq_pending)
      `CHK("int out", 1'b1, int_out)
      irq_mask = 8'h01 << i;
      ext_irq_line = 0;
      repeat (2) @(negedge sys_clk);
      `CHK("int masked", 1'b0, int_out)
      irq_clear = 8'h01 << i;
      @(negedge sys_clk);
      irq_clear = 0;
      irq_mask = 0;
    end
    @(negedge sys_clk);
    `CHK("irq cleared", 8'h00, irq_pending)
    nmi_in = 1;
    @(negedge sys_clk);
    `CHK("core nmi", 1'b1, core_nmi_req)
    repeat (3) @(negedge sys_clk);
    nmi_in = 0;
    `CHK("nmi held", 1'b1, nmi_out)
    nmi_serviced = 1;
    @(negedge sys_clk);
    nmi_serviced = 0;
    @(negedge sys_clk);
    `CHK("nmi serviced", 1'b0, nmi_out)
    `CHK("beats missing", 0, exp_q.size())
    results();
  end
endmodule
